/* File: gf_stage_pkg.sv */
// Purpose: Shared constants, types and helpers for the ground fault stages
// Assumes: 10 MHz clock, one processing tick per millisecond
// Notes:   Currents and pickups share one unit: the pickup setting step
package gf_stage_pkg;

  localparam int CLOCK_PERIOD_NS     = 100;
  localparam int TICK_PERIOD_US      = 1000;
  localparam int TICK_CYCLES_DEFAULT = TICK_PERIOD_US * 1000 / CLOCK_PERIOD_NS;

  localparam int OFF_DELAY_MS       = 200;
  localparam int INST_RELEASE_MS    = 50;
  localparam int DT_TIMER_RESET_MS  = 8000;
  localparam int DELAY_STEP_MS      = 10;
  // Minimum times round up, the maximum release time rounds down
  localparam int OFF_DELAY_TICKS    = (OFF_DELAY_MS * 1000 + TICK_PERIOD_US - 1) / TICK_PERIOD_US;
  localparam int INST_RELEASE_TICKS = INST_RELEASE_MS * 1000 / TICK_PERIOD_US;
  localparam int DT_RESET_TICKS     = (DT_TIMER_RESET_MS * 1000 + TICK_PERIOD_US - 1) / TICK_PERIOD_US;
  localparam int DELAY_STEP_TICKS   = (DELAY_STEP_MS * 1000 + TICK_PERIOD_US - 1) / TICK_PERIOD_US;

  localparam int CUR_W  = 16;
  localparam int CNT_W  = 14;
  localparam int ACC_W  = 32;
  localparam int MULT_W = 13;
  localparam int DLY_W  = 10;

  localparam logic [7:0] ADDR_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_S3_PICKUP = 8'h04;
  localparam logic [7:0] ADDR_S3_DELAY  = 8'h08;
  localparam logic [7:0] ADDR_S4_PICKUP = 8'h0C;
  localparam logic [7:0] ADDR_S4_MULT   = 8'h10;
  localparam logic [7:0] ADDR_S4_CURVE  = 8'h14;
  localparam logic [7:0] ADDR_STATUS    = 8'h18;

  localparam int CTL_S3_EN   = 0;
  localparam int CTL_S3_HARM = 1;
  localparam int CTL_S4_EN   = 2;
  localparam int CTL_S4_HARM = 3;
  localparam int CTL_S4_STD  = 4;
  localparam int CTL_W       = 5;
  localparam int CURVE_OP_LSB  = 0;
  localparam int CURVE_RST_LSB = 4;

  localparam int DELAY_CODE_MAX = 1000;
  localparam int MULT_MIN       = 25;
  localparam int MULT_MAX       = 5000;
  localparam int CBT_PICKUP_MIN = 2;
  localparam int CBT_PICKUP_MAX = 200;
  localparam int RES_PICKUP_MIN = 1;
  localparam int RES_PICKUP_MAX = 1000;
  localparam int DT_TICKS_PER_M = 1;
  localparam int IDMT_SCALE_DEFAULT = 1000;
  localparam logic [7:0] UNIT_PCT = 8'h64;
  localparam logic [7:0] STD_PCT  = 8'h73;

  localparam logic [CTL_W-1:0]  CONTROL_RESET = 5'h00;
  localparam logic [DLY_W-1:0]  DELAY_RESET   = 10'h000;
  localparam logic [MULT_W-1:0] MULT_RESET    = 13'h0064;

  localparam int CURVE_COUNT      = 14;
  localparam int RESET_CHAR_COUNT = 3;
  typedef enum logic [3:0] {
    curve_ni01 = 4'h0, curve_vi01 = 4'h1, curve_ei01 = 4'h2, curve_li01 = 4'h3,
    curve_li02 = 4'h4, curve_dt01 = 4'h5, curve_ni11 = 4'h6, curve_ei11 = 4'h7,
    curve_ei12 = 4'h8, curve_ni21 = 4'h9, curve_vi21 = 4'hA, curve_li21 = 4'hB,
    curve_ni31 = 4'hC, curve_vi31 = 4'hD
  } op_curve_e;
  typedef enum logic [1:0] {reset_idmt = 2'h0, reset_dt = 2'h1, reset_inst = 2'h2} reset_char_e;

  // Scaled compare avoids a divider: cur*100 >= pk*pct
  function automatic logic reaches_pickup(input logic [CUR_W-1:0] cur, input logic [CUR_W-1:0] pk,
                                          input logic [7:0] pct);
    return ({8'h00, cur} * {16'h0000, UNIT_PCT}) >= ({8'h00, pk} * {16'h0000, pct});
  endfunction

endpackage

/* File: stage_if.sv */
// Purpose: Carries settings and live inputs to a definite-time stage
// Assumes: Driven by the top, one clock domain
// Notes:   clear wins over tick in the stage
`timescale 1ns/1ps
interface stage_if;
  import gf_stage_pkg::*;
  logic             tick;
  logic             clear;
  logic             use_enable;
  logic             harmonic_block_enable;
  logic             restraint;
  logic [CUR_W-1:0] current;
  logic [CUR_W-1:0] pickup;
  logic [CNT_W-1:0] delay_ticks;
  logic             detect;
  logic             trip;
  modport ctrl  (output tick, clear, use_enable, harmonic_block_enable, restraint, current, pickup,
                 delay_ticks, input detect, trip);
  modport stage (input tick, clear, use_enable, harmonic_block_enable, restraint, current, pickup,
                 delay_ticks, output detect, trip);
endinterface

/* File: dt_ground_stage.sv */
// Purpose: Definite-time ground stage with optional harmonic blocking
// Assumes: One tick pulse per processing period
// Notes:   Trip is held by an off-delay after detection drops
`timescale 1ns/1ps
module dt_ground_stage
  import gf_stage_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  stage_if.stage   link
);

  logic [CNT_W-1:0] run_cnt;
  logic [CNT_W-1:0] hold_cnt;
  logic             detect;
  logic             trip;

  wire blocked   = link.harmonic_block_enable & link.restraint;
  wire det_now   = link.use_enable & !blocked & reaches_pickup(link.current, link.pickup, UNIT_PCT);
  wire expired   = run_cnt >= link.delay_ticks;
  wire hold_done = hold_cnt == CNT_W'(OFF_DELAY_TICKS - 1);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_cnt  <= '0;
      hold_cnt <= '0;
      detect   <= 1'b0;
      trip     <= 1'b0;
    end else if (link.clear || !link.use_enable) begin
      run_cnt  <= '0;
      hold_cnt <= '0;
      detect   <= 1'b0;
      trip     <= 1'b0;
    end else if (link.tick) begin
      detect <= det_now;
      if (det_now) begin
        hold_cnt <= '0;
        if (expired) trip <= 1'b1;
        else run_cnt <= run_cnt + 1'b1;
      end else begin
        run_cnt <= '0;
        if (trip && hold_done) begin
          trip     <= 1'b0;
          hold_cnt <= '0;
        end else if (trip) begin
          hold_cnt <= hold_cnt + 1'b1;
        end
      end
    end
  end

  assign link.detect = detect;
  assign link.trip   = trip;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_s3_restraint_block: assert property (
    link.tick && link.harmonic_block_enable && link.restraint && !link.clear |=> !detect)
    else $error("stage three detected under harmonic restraint");
  a_s3_trip_delay: assert property ($rose(trip) |-> $past(expired) && $past(det_now))
    else $error("stage three tripped before its delay");
  a_s3_hold_offdelay: assert property (
    $fell(trip) && $past(link.use_enable) && !$past(link.clear) |-> $past(hold_done))
    else $error("stage three released before off-delay");
  a_s3_setting_clear: assert property (link.clear |=> !trip && run_cnt == '0)
    else $error("stage three not cleared on setting change");
  a_s3_tick_only: assert property (
    !link.tick && !link.clear && link.use_enable |=> $stable(run_cnt) && $stable(trip))
    else $error("stage three changed between ticks");

endmodule

/* File: ground_fault_overcurrent_stage.sv */
// Purpose: Third and fourth ground fault overcurrent stages with settings port
// Assumes: Current and curve rate arrive synchronous, in pickup step units
// Notes:   Curve shapes are evaluated outside; this block only accumulates
//
// Summary of operation
// - Stage three is definite time, harmonically blockable
// - Trip after timer; 200 ms off-delay hold
// - Delay 0.00 to 10.00 s, fast instantaneous
// - Core-balance pickup 1.0 to 100.0 mA
// - Residual pickup 0.1 to 100.0 A
// - Stage four trips after characteristic time elapses
// - Detection at pickup, or 1.15 times pickup
// - Timer accumulates only at or above pickup, unblocked
// - Restraint ignored when blocking disabled
// - Fourteen operating, three reset characteristics
// - Curves encoded as distinct enumerated values
// - Multiplier 0.25 to 50.00 scales curve
// - Inverse or definite reset holds 200 ms
// - Definite reset clears timer after fixed 8000 ms
// - Instantaneous reset releases within 50 ms
// - Stage four silent unless enabled
`timescale 1ns/1ps
module ground_fault_overcurrent_stage
  import gf_stage_pkg::*;
#(
  parameter int TICK_CYCLES  = TICK_CYCLES_DEFAULT,
  parameter bit CORE_BALANCE = 1'b1,
  parameter int IDMT_SCALE   = IDMT_SCALE_DEFAULT
)(
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic [7:0]       i_addr,
  input  wire logic [31:0]      i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic      [31:0]      o_rdata,
  input  wire logic [CUR_W-1:0] i_current,
  input  wire logic             i_restraint,
  input  wire logic [15:0]      i_curve_rate,
  output logic      [3:0]       o_curve_select,
  output logic                  o_trip_three,
  output logic                  o_trip_four
);

  localparam logic [CUR_W-1:0] PICKUP_MIN = CORE_BALANCE ? CUR_W'(CBT_PICKUP_MIN) : CUR_W'(RES_PICKUP_MIN);
  localparam logic [CUR_W-1:0] PICKUP_MAX = CORE_BALANCE ? CUR_W'(CBT_PICKUP_MAX) : CUR_W'(RES_PICKUP_MAX);

  generate
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
      $error("TICK_CYCLES must lie in 1..65535");
    end
    if (IDMT_SCALE < 1 || IDMT_SCALE > 65535) begin : g_bad_scale
      $error("IDMT_SCALE must lie in 1..65535");
    end
    if (INST_RELEASE_TICKS < 1 || DT_RESET_TICKS >= (1 << CNT_W)) begin : g_bad_timing
      $error("tick period does not suit the reset timing");
    end
  endgenerate

  // Range check shared by both pickup registers; out-of-range writes are dropped
  function automatic logic pickup_ok(input logic [31:0] v);
    return v >= {16'h0000, PICKUP_MIN} && v <= {16'h0000, PICKUP_MAX};
  endfunction

  logic [15:0]       tick_cnt;
  logic [CTL_W-1:0]  control;
  logic [CUR_W-1:0]  s3_pickup;
  logic [DLY_W-1:0]  s3_delay;
  logic [CUR_W-1:0]  s4_pickup;
  logic [MULT_W-1:0] s4_mult;
  op_curve_e         s4_curve;
  reset_char_e       s4_reset;
  logic [ACC_W-1:0]  acc;
  logic [CNT_W-1:0]  rst_cnt;
  logic [CNT_W-1:0]  hold4;
  logic              detect4;
  logic              trip4;

  wire tick = tick_cnt == 16'(TICK_CYCLES - 1);

  wire sel_control = i_addr == ADDR_CONTROL;
  wire sel_s3_pk   = i_addr == ADDR_S3_PICKUP;
  wire sel_s3_dly  = i_addr == ADDR_S3_DELAY;
  wire sel_s4_pk   = i_addr == ADDR_S4_PICKUP;
  wire sel_s4_mult = i_addr == ADDR_S4_MULT;
  wire sel_s4_crv  = i_addr == ADDR_S4_CURVE;
  wire sel_status  = i_addr == ADDR_STATUS;

  wire [3:0] wr_curve = i_wdata[CURVE_OP_LSB +: 4];
  wire [1:0] wr_reset = i_wdata[CURVE_RST_LSB +: 2];
  wire wr_control = i_wr && sel_control;
  wire wr_s3_pk   = i_wr && sel_s3_pk && pickup_ok(i_wdata);
  wire wr_s3_dly  = i_wr && sel_s3_dly && i_wdata <= 32'(DELAY_CODE_MAX);
  wire wr_s4_pk   = i_wr && sel_s4_pk && pickup_ok(i_wdata);
  wire wr_s4_mult = i_wr && sel_s4_mult && i_wdata >= 32'(MULT_MIN) && i_wdata <= 32'(MULT_MAX);
  wire wr_s4_crv  = i_wr && sel_s4_crv && i_wdata[31:6] == 26'h0 && 32'(wr_curve) < 32'(CURVE_COUNT)
                    && 32'(wr_reset) < 32'(RESET_CHAR_COUNT);

  wire s3_ctl_change = wr_control && (i_wdata[CTL_S3_HARM:CTL_S3_EN] != control[CTL_S3_HARM:CTL_S3_EN]);
  wire s4_ctl_change = wr_control && (i_wdata[CTL_S4_STD:CTL_S4_EN] != control[CTL_S4_STD:CTL_S4_EN]);
  // Clear lands on the same edge as the new value, so no tick ever mixes old timers and new settings
  wire clear3 = s3_ctl_change || wr_s3_pk || wr_s3_dly;
  wire clear4 = s4_ctl_change || wr_s4_pk || wr_s4_mult || wr_s4_crv;

  wire en4   = control[CTL_S4_EN];
  wire harm4 = control[CTL_S4_HARM];
  wire std4  = control[CTL_S4_STD];

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) tick_cnt <= '0;
    else if (tick) tick_cnt <= '0;
    else tick_cnt <= tick_cnt + 1'b1;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      control   <= CONTROL_RESET;
      s3_pickup <= PICKUP_MIN;
      s3_delay  <= DELAY_RESET;
      s4_pickup <= PICKUP_MIN;
      s4_mult   <= MULT_RESET;
      s4_curve  <= curve_ni01;
      s4_reset  <= reset_idmt;
    end else begin
      if (wr_control) control <= i_wdata[CTL_W-1:0];
      if (wr_s3_pk) s3_pickup <= i_wdata[CUR_W-1:0];
      if (wr_s3_dly) s3_delay <= i_wdata[DLY_W-1:0];
      if (wr_s4_pk) s4_pickup <= i_wdata[CUR_W-1:0];
      if (wr_s4_mult) s4_mult <= i_wdata[MULT_W-1:0];
      if (wr_s4_crv) begin
        s4_curve <= op_curve_e'(wr_curve);
        s4_reset <= reset_char_e'(wr_reset);
      end
    end
  end

  stage_if s3_link ();
  assign s3_link.tick                  = tick;
  assign s3_link.clear                 = clear3;
  assign s3_link.use_enable            = control[CTL_S3_EN];
  assign s3_link.harmonic_block_enable = control[CTL_S3_HARM];
  assign s3_link.restraint             = i_restraint;
  assign s3_link.current               = i_current;
  assign s3_link.pickup                = s3_pickup;
  // Widen before the product: the longest delay code times its step does not fit the code width
  assign s3_link.delay_ticks           = CNT_W'(s3_delay) * CNT_W'(DELAY_STEP_TICKS);

  dt_ground_stage u_stage_three (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .link    (s3_link.stage)
  );

  // Harmonic restraint only counts when blocking is enabled
  wire blocked4  = harm4 & i_restraint;
  wire det4_now  = en4 & !blocked4 & reaches_pickup(i_current, s4_pickup, std4 ? STD_PCT : UNIT_PCT);
  wire timing4   = en4 & !blocked4 & reaches_pickup(i_current, s4_pickup, UNIT_PCT);
  wire is_dt     = s4_curve == curve_dt01;
  wire [ACC_W-1:0] step4   = is_dt ? ACC_W'(DT_TICKS_PER_M) : {16'h0000, i_curve_rate};
  wire [ACC_W-1:0] mult_x  = {19'h00000, s4_mult};
  wire [ACC_W-1:0] target4 = is_dt ? ACC_W'(mult_x * ACC_W'(DT_TICKS_PER_M))
                                   : ACC_W'(mult_x * ACC_W'(IDMT_SCALE));
  wire [ACC_W:0]   acc_sum  = {1'b0, acc} + {1'b0, step4};
  wire [ACC_W-1:0] next_acc = acc_sum[ACC_W] ? {ACC_W{1'b1}} : acc_sum[ACC_W-1:0];
  wire expired4   = acc >= target4;
  wire hold_done4 = hold4 == CNT_W'(OFF_DELAY_TICKS - 1);
  wire dt_done4   = rst_cnt == CNT_W'(DT_RESET_TICKS - 1);

  // Accumulator: stalls at the target, and under definite reset it clears only after a long idle
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc     <= '0;
      rst_cnt <= '0;
    end else if (clear4 || !en4) begin
      acc     <= '0;
      rst_cnt <= '0;
    end else if (tick) begin
      if (timing4) begin
        rst_cnt <= '0;
        if (!expired4) acc <= next_acc;
      end else if (s4_reset == reset_dt && acc != '0) begin
        if (dt_done4) begin
          acc     <= '0;
          rst_cnt <= '0;
        end else begin
          rst_cnt <= rst_cnt + 1'b1;
        end
      end else begin
        acc     <= '0;
        rst_cnt <= '0;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      detect4 <= 1'b0;
      trip4   <= 1'b0;
      hold4   <= '0;
    end else if (clear4 || !en4) begin
      detect4 <= 1'b0;
      trip4   <= 1'b0;
      hold4   <= '0;
    end else if (tick) begin
      detect4 <= det4_now;
      if (det4_now) begin
        hold4 <= '0;
        if (expired4) trip4 <= 1'b1;
      end else if (trip4) begin
        case (s4_reset)
          reset_inst: trip4 <= 1'b0;
          reset_idmt, reset_dt: begin
            if (hold_done4) begin
              trip4 <= 1'b0;
              hold4 <= '0;
            end else begin
              hold4 <= hold4 + 1'b1;
            end
          end
          default: trip4 <= 1'b0;
        endcase
      end
    end
  end

  wire [31:0] status = {27'h0, acc != '0, detect4, trip4, s3_link.detect, s3_link.trip};
  wire [31:0] read_mux =
    sel_control ? {27'h0, control} :
    sel_s3_pk   ? {16'h0000, s3_pickup} :
    sel_s3_dly  ? {22'h0, s3_delay} :
    sel_s4_pk   ? {16'h0000, s4_pickup} :
    sel_s4_mult ? {19'h0, s4_mult} :
    sel_s4_crv  ? {26'h0, s4_reset, s4_curve} :
    sel_status  ? status : 32'h0000_0000;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) o_rdata <= '0;
    else o_rdata <= i_rd ? read_mux : 32'h0000_0000;
  end

  assign o_curve_select = s4_curve;
  assign o_trip_three   = s3_link.trip;
  assign o_trip_four    = trip4;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_detect_drop;
    tick && en4 && !clear4 && !det4_now;
  endsequence
  sequence s_unblocked_pickup;
    tick && en4 && !clear4 && !harm4 && !std4 && reaches_pickup(i_current, s4_pickup, UNIT_PCT);
  endsequence

  a_s4_enable_gate: assert property (!en4 |=> !trip4)
    else $error("stage four trip while disabled");
  a_s4_inst_release: assert property (s_detect_drop and s4_reset == reset_inst |=> !trip4)
    else $error("instantaneous reset did not release");
  a_s4_offdelay_hold: assert property (
    $fell(trip4) && $past(en4) && !$past(clear4) && $past(s4_reset) != reset_inst |-> $past(hold_done4))
    else $error("stage four released before off-delay");
  a_s4_trip_time: assert property ($rose(trip4) |-> $past(det4_now) && $past(expired4))
    else $error("stage four tripped before characteristic time");
  a_s4_std_threshold: assert property (
    tick && en4 && std4 && !clear4 && !reaches_pickup(i_current, s4_pickup, STD_PCT) |=> !detect4)
    else $error("raised threshold not applied");
  a_s4_harm_ignored: assert property (s_unblocked_pickup |=> detect4)
    else $error("restraint acted while blocking disabled");
  a_s4_acc_blocked: assert property (
    tick && en4 && !clear4 && blocked4 && s4_reset == reset_idmt |=> acc == '0)
    else $error("timer ran under restraint");
  a_s4_setting_clear: assert property (clear4 |=> !trip4 && acc == '0 && hold4 == '0)
    else $error("setting change did not clear stage four");
  a_s4_tick_only: assert property (!tick && !clear4 && en4 |=> $stable(acc) && $stable(trip4))
    else $error("stage four changed between ticks");
  a_s4_curve_legal: assert property (32'(s4_curve) < 32'(CURVE_COUNT) && s4_reset != 2'h3)
    else $error("illegal characteristic selected");

endmodule

/* File: front_end_model.sv */
// Purpose: Stand-in for the zero-sequence measurement front end
// Assumes: One clock; the bench asks for levels, the model presents them
// Notes:   Levels appear one clock after they are asked for, like a sampled front end
`timescale 1ns/1ps
module front_end_model
  import gf_stage_pkg::*;
(
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic [CUR_W-1:0] i_level,
  input  wire logic             i_harm,
  input  wire logic [15:0]      i_rate,
  output logic      [CUR_W-1:0] o_current,
  output logic                  o_restraint,
  output logic      [15:0]      o_curve_rate
);
  // Measurement keeps running through a relay reset, so no reset branch
  always_ff @(posedge i_clock) begin
    o_current    <= i_level;
    o_restraint  <= i_harm;
    o_curve_rate <= i_rate;
  end
endmodule

/* File: ground_fault_overcurrent_stage_tb_top.sv */
// Purpose: Self-checking bench for the third and fourth ground stages
// Assumes: Tick shortened to 10 clocks, so one tick stands for 1 ms
// Notes:   Windows allow two ticks of slack for tick phase and model delay
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module ground_fault_overcurrent_stage_tb_top;
  import gf_stage_pkg::*;
  typedef struct {logic wr; logic [7:0] addr; logic [15:0] wdata; logic [15:0] want;} row_s;
  logic             i_clock = 1'b0;
  logic             i_rst_n = 1'b0;
  logic             i_wr    = 1'b0;
  logic             i_rd    = 1'b0;
  logic             harm    = 1'b0;
  logic [7:0]       i_addr  = 8'h00;
  logic [31:0]      i_wdata = 32'h0;
  logic [31:0]      o_rdata;
  logic [31:0]      v;
  logic [CUR_W-1:0] level   = 16'h0000;
  logic [CUR_W-1:0] i_current;
  logic [15:0]      rate    = 16'h0000;
  logic [15:0]      i_curve_rate;
  logic             i_restraint;
  logic [3:0]       o_curve_select;
  logic             o_trip_three;
  logic             o_trip_four;
  int               errors;
  int               check_count;
  int               cycles;
  row_s rows [20] = '{
    '{1'b0, 8'h00, 16'h0, 16'h0000}, '{1'b0, 8'h04, 16'h0, 16'h0002}, '{1'b0, 8'h08, 16'h0, 16'h0000},
    '{1'b0, 8'h0C, 16'h0, 16'h0002}, '{1'b0, 8'h10, 16'h0, 16'h0064}, '{1'b0, 8'h14, 16'h0, 16'h0000},
    '{1'b0, 8'h18, 16'h0, 16'h0000}, '{1'b0, 8'h1C, 16'h0, 16'h0000}, '{1'b1, 8'h04, 16'h00C8, 16'h00C8},
    '{1'b1, 8'h04, 16'h00C9, 16'h00C8}, '{1'b1, 8'h04, 16'h0001, 16'h00C8}, '{1'b1, 8'h08, 16'h03E8, 16'h03E8},
    '{1'b1, 8'h08, 16'h03E9, 16'h03E8}, '{1'b1, 8'h10, 16'h0018, 16'h0064}, '{1'b1, 8'h10, 16'h1388, 16'h1388},
    '{1'b1, 8'h10, 16'h1389, 16'h1388}, '{1'b1, 8'h14, 16'h000E, 16'h0000}, '{1'b1, 8'h14, 16'h0030, 16'h0000},
    '{1'b1, 8'h18, 16'h00FF, 16'h0000}, '{1'b1, 8'h1C, 16'h0005, 16'h0000}};

  ground_fault_overcurrent_stage #(.TICK_CYCLES(10), .CORE_BALANCE(1'b1), .IDMT_SCALE(4))
  i_ground_fault_overcurrent_stage (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_current(i_current), .i_restraint(i_restraint), .i_curve_rate(i_curve_rate),
    .o_curve_select(o_curve_select), .o_trip_three(o_trip_three), .o_trip_four(o_trip_four));
  front_end_model i_front_end_model (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_level(level), .i_harm(harm), .i_rate(rate),
    .o_current(i_current), .o_restraint(i_restraint), .o_curve_rate(i_curve_rate));

  always #50 i_clock = ~i_clock;

  // Ceiling sits well above the roughly 9000 cycles the sequence needs
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic drive(input logic [15:0] c, input logic h, input logic [15:0] r);
    @(posedge i_clock);
    level <= c;
    harm  <= h;
    rate  <= r;
  endtask

  function automatic logic trip(input bit four);
    return four ? o_trip_four : o_trip_three;
  endfunction

  // Holds its old value for lo ticks, then must change by hi ticks
  task automatic timed(input bit four, input int lo, input int hi, input logic was);
    int n;
    n = 0;
    repeat (lo * 10) @(posedge i_clock);
    #1;
    `CHK(trip(four), was)
    while (trip(four) === was && n < (hi - lo) * 10) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    `CHK(trip(four), ~was)
  endtask

  task automatic quiet(input bit four, input int ticks);
    logic seen;
    seen = 1'b0;
    repeat (ticks * 10) begin
      @(posedge i_clock);
      #1;
      seen = seen | (trip(four) !== 1'b0);
    end
    `CHK(seen, 1'b0)
  endtask

  initial begin
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].addr, {16'h0000, rows[i].wdata});
      rd(rows[i].addr, v);
      `CHK(v, {16'h0000, rows[i].want})
    end
    for (int c = 0; c < CURVE_COUNT; c++) begin
      wr(ADDR_S4_CURVE, 32'(c));
      @(posedge i_clock);
      #1;
      `CHK(o_curve_select, 4'(c))
    end
    wr(ADDR_S3_PICKUP, 32'h14);
    wr(ADDR_S3_DELAY, 32'h1);
    wr(ADDR_CONTROL, 32'h3);
    drive(16'h0014, 1'b1, 16'h0);
    quiet(1'b0, 30);
    drive(16'h0014, 1'b0, 16'h0);
    timed(1'b0, 9, 14, 1'b0);
    rd(ADDR_STATUS, v);
    `CHK(v, 32'h3)
    drive(16'h0013, 1'b0, 16'h0);
    timed(1'b0, 197, 203, 1'b1);
    wr(ADDR_S3_DELAY, 32'h0);
    drive(16'h0014, 1'b0, 16'h0);
    timed(1'b0, 0, 3, 1'b0);
    wr(ADDR_S4_PICKUP, 32'h14);
    wr(ADDR_S4_MULT, 32'h19);
    wr(ADDR_S4_CURVE, 32'h25);
    wr(ADDR_CONTROL, 32'h4);
    timed(1'b1, 24, 29, 1'b0);
    drive(16'h0000, 1'b0, 16'h0);
    timed(1'b1, 0, 3, 1'b1);
    wr(ADDR_S4_CURVE, 32'h15);
    drive(16'h0014, 1'b0, 16'h0);
    timed(1'b1, 24, 29, 1'b0);
    drive(16'h0000, 1'b0, 16'h0);
    timed(1'b1, 197, 203, 1'b1);
    wr(ADDR_S4_CURVE, 32'h0);
    drive(16'h0014, 1'b0, 16'h5);
    timed(1'b1, 17, 24, 1'b0);
    drive(16'h0000, 1'b0, 16'h5);
    timed(1'b1, 197, 203, 1'b1);
    wr(ADDR_CONTROL, 32'h14);
    wr(ADDR_S4_CURVE, 32'h25);
    drive(16'h0016, 1'b0, 16'h0);
    quiet(1'b1, 40);
    // Between pickup and the raised threshold the timer runs but nothing is detected
    rd(ADDR_STATUS, v);
    `CHK(v, 32'h10)
    drive(16'h0017, 1'b0, 16'h0);
    timed(1'b1, 0, 3, 1'b0);
    wr(ADDR_CONTROL, 32'h4);
    drive(16'h0014, 1'b1, 16'h0);
    timed(1'b1, 24, 29, 1'b0);
    wr(ADDR_CONTROL, 32'hC);
    quiet(1'b1, 40);
    wr(ADDR_CONTROL, 32'h4);
    timed(1'b1, 24, 29, 1'b0);
    rd(ADDR_STATUS, v);
    `CHK(v, 32'h1C)
    wr(ADDR_S4_MULT, 32'h1E);
    @(posedge i_clock);
    #1;
    `CHK(o_trip_four, 1'b0)
    wr(ADDR_CONTROL, 32'h0);
    quiet(1'b1, 40);
    // Restraint still present but not blocking, so stage three trips before the reset
    wr(ADDR_CONTROL, 32'h1);
    repeat (30) @(posedge i_clock);
    #1;
    `CHK(o_trip_three, 1'b1)
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    #1;
    `CHK(o_trip_three, 1'b0)
    @(posedge i_clock);
    i_rst_n <= 1'b1;
    rd(ADDR_S4_MULT, v);
    `CHK(v, 32'h64)
    tally_and_finish();
  end
endmodule
